/* pust_sequencer.sv */
// Power-up self-test sequencer: panel lamps, four ordered checks, fault codes, tone, preset.
// Assumes test engines answer each start with a one-cycle done and pass flag,
// and that all panel inputs are synchronous to core_clk_i.
module pust_sequencer #(
    parameter int unsigned DARK_CYC = pust_pkg::DARK_CYC,
    parameter int unsigned LAMP_CYC = pust_pkg::LAMP_CYC,
    parameter int unsigned TONE_CYC = pust_pkg::TONE_CYC
) (
    input  wire logic                            core_clk_i,
    input  wire logic                            arst_n_i,
    input  wire logic                            backup_pwr_i,
    input  wire logic                            beeper_en_i,
    input  wire logic [pust_pkg::VERT_W-1:0]     vert_btn_i,
    input  wire logic [pust_pkg::HORZ_W-1:0]     horiz_btn_i,
    input  wire logic [pust_pkg::TRIG_W-1:0]     trig_a_sel_i,
    input  wire logic [pust_pkg::TRIG_W-1:0]     trig_b_sel_i,
    input  wire logic [pust_pkg::PLUG_W-1:0]     plugin_sel_i,
    input  wire pust_pkg::pust_test_rsp_t        test_rsp_i,
    output logic                                 power_lamp_o,
    output logic [pust_pkg::TRIG_W-1:0]          trig_a_lamp_o,
    output logic [pust_pkg::TRIG_W-1:0]          trig_b_lamp_o,
    output logic [pust_pkg::PLUG_W-1:0]          plugin_lamp_o,
    output pust_pkg::pust_lamps_t                lamps_o,
    output pust_pkg::pust_test_req_t             test_req_o,
    output logic                                 tone_o,
    output pust_pkg::pust_msg_t                  msg_o,
    output pust_pkg::pust_preset_t               preset_o,
    output logic                                 busy_o,
    output logic                                 fail_o
);

    typedef struct packed {
        pust_pkg::pust_state_t              st;
        logic [31:0]                        cnt;
        logic [1:0]                         idx;
        logic                               failed;
        logic                               btn_prev;
        logic                               power;
        logic [pust_pkg::TRIG_W-1:0]        trig_a;
        logic [pust_pkg::TRIG_W-1:0]        trig_b;
        logic [pust_pkg::PLUG_W-1:0]        plug;
        pust_pkg::pust_lamps_t              lamps;
        pust_pkg::pust_test_req_t           req;
        logic                               tone;
        pust_pkg::pust_msg_t                msg;
        pust_pkg::pust_preset_t             preset;
        logic                               busy;
        logic                               fail;
    } pust_seq_state_t;

    pust_seq_state_t s_r;
    pust_seq_state_t s_nxt;
    logic            btn_any;

    // Horizontal fault pattern per check
    function automatic logic [pust_pkg::HORZ_W-1:0] fault_horiz(input logic [1:0] idx);
        logic [pust_pkg::HORZ_W-1:0] h;
        h = '0;
        case (idx)
            pust_pkg::TEST_RAM: begin
                h[pust_pkg::H_B] = 1'b1;
            end
            pust_pkg::TEST_ROM: begin
                h[pust_pkg::H_INTL] = 1'b1;
            end
            pust_pkg::TEST_RTC: begin
                h[pust_pkg::H_INTL] = 1'b1;
                h[pust_pkg::H_B] = 1'b1;
            end
            default: begin
                h[pust_pkg::H_SWAP] = 1'b1;
            end
        endcase
        return h;
    endfunction : fault_horiz

    // Final panel pattern after a clean pass
    function automatic pust_pkg::pust_lamps_t pass_lamps();
        pust_pkg::pust_lamps_t l;
        l = '0;
        l.vert[pust_pkg::V_LEFT] = 1'b1;
        l.horiz[pust_pkg::H_B] = 1'b1;
        l.inten[pust_pkg::I_B] = 1'b1;
        return l;
    endfunction : pass_lamps

    assign btn_any = (|vert_btn_i) | (|horiz_btn_i);

    always_comb begin
        s_nxt = s_r;
        s_nxt.btn_prev = btn_any;
        s_nxt.req.start = 1'b0;
        s_nxt.msg.wr = 1'b0;
        s_nxt.preset.load = 1'b0;
        // Power lamp lit; trigger and plug-in lamps follow their switches from power-on
        s_nxt.power = 1'b1;
        s_nxt.trig_a = trig_a_sel_i;
        s_nxt.trig_b = trig_b_sel_i;
        s_nxt.plug = plugin_sel_i;
        case (s_r.st)
            pust_pkg::ST_DARK: begin
                s_nxt.lamps = '0;
                s_nxt.cnt = s_r.cnt + 32'h1;
                if (s_r.cnt >= DARK_CYC - 1) begin
                    s_nxt.cnt = '0;
                    s_nxt.lamps = '1;
                    s_nxt.st = pust_pkg::ST_LAMP;
                end
            end
            pust_pkg::ST_LAMP: begin
                s_nxt.cnt = s_r.cnt + 32'h1;
                if (s_r.cnt >= LAMP_CYC - 1) begin
                    s_nxt.cnt = '0;
                    if (backup_pwr_i) begin
                        // Memory was kept alive: no checks, no preset
                        s_nxt.lamps = pass_lamps();
                        s_nxt.busy = 1'b0;
                        s_nxt.st = pust_pkg::ST_DONE;
                    end else begin
                        s_nxt.idx = pust_pkg::TEST_RAM;
                        s_nxt.st = pust_pkg::ST_START;
                    end
                end
            end
            pust_pkg::ST_START: begin
                s_nxt.req.start = 1'b1;
                s_nxt.req.sel = s_r.idx;
                s_nxt.st = pust_pkg::ST_WAIT;
            end
            pust_pkg::ST_WAIT: begin
                if (test_rsp_i.done) begin
                    if (!test_rsp_i.pass) begin
                        s_nxt.failed = 1'b1;
                        s_nxt.lamps = '0;
                        s_nxt.lamps.vert = '1;
                        s_nxt.lamps.horiz = fault_horiz(s_r.idx);
                        s_nxt.st = pust_pkg::ST_FAULT;
                    end else if (s_r.idx == pust_pkg::TEST_LAST) begin
                        s_nxt.st = pust_pkg::ST_TONE;
                    end else begin
                        s_nxt.idx = s_r.idx + 2'h1;
                        s_nxt.st = pust_pkg::ST_START;
                    end
                end
            end
            pust_pkg::ST_FAULT: begin
                // A fresh press only, so a button held at power-on does not skip codes
                if (btn_any && !s_r.btn_prev) begin
                    s_nxt.lamps = '1;
                    if (s_r.idx == pust_pkg::TEST_LAST) begin
                        s_nxt.st = pust_pkg::ST_TONE;
                    end else begin
                        s_nxt.idx = s_r.idx + 2'h1;
                        s_nxt.st = pust_pkg::ST_START;
                    end
                end
            end
            pust_pkg::ST_TONE: begin
                if (s_r.failed) begin
                    s_nxt.fail = 1'b1;
                    s_nxt.busy = 1'b0;
                    s_nxt.st = pust_pkg::ST_DONE;
                end else begin
                    s_nxt.lamps = pass_lamps();
                    if (s_r.cnt == 32'h0) begin
                        s_nxt.msg.wr = 1'b1;
                        s_nxt.msg.id = pust_pkg::MSG_SELF_TEST_COMPLETE;
                        s_nxt.preset.load = 1'b1;
                        s_nxt.preset.run_program_state = 1'b1;
                        s_nxt.preset.clear_prog_mem = 1'b1;
                        s_nxt.preset.clear_stack = 1'b1;
                        s_nxt.preset.points = pust_pkg::PRESET_POINTS;
                    end
                    s_nxt.tone = beeper_en_i;
                    s_nxt.cnt = s_r.cnt + 32'h1;
                    if (s_r.cnt >= TONE_CYC) begin
                        s_nxt.tone = 1'b0;
                        s_nxt.cnt = '0;
                        s_nxt.busy = 1'b0;
                        s_nxt.st = pust_pkg::ST_DONE;
                    end
                end
            end
            pust_pkg::ST_DONE: begin
                s_nxt.tone = 1'b0;
            end
            default: begin
                s_nxt.st = pust_pkg::ST_DARK;
                s_nxt.cnt = '0;
            end
        endcase
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_r <= '0;
            s_r.st <= pust_pkg::ST_DARK;
            s_r.busy <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign power_lamp_o  = s_r.power;
    assign trig_a_lamp_o = s_r.trig_a;
    assign trig_b_lamp_o = s_r.trig_b;
    assign plugin_lamp_o = s_r.plug;
    assign lamps_o       = s_r.lamps;
    assign test_req_o    = s_r.req;
    assign tone_o        = s_r.tone;
    assign msg_o         = s_r.msg;
    assign preset_o      = s_r.preset;
    assign busy_o        = s_r.busy;
    assign fail_o        = s_r.fail;

endmodule : pust_sequencer

/* pust_pkg.sv */
// Package for the power-up self-test sequencer: lamp layout, timing, states, carriers.
// Assumes a single 25 MHz system clock and an asynchronous active-low power-on reset.
package pust_pkg;

    // Clock rate and times
    localparam int unsigned CLK_KHZ      = 25000;
    localparam int unsigned DARK_MS      = 3000;
    localparam int unsigned LAMP_TEST_MS = 1000;
    localparam int unsigned TONE_MS      = 100;
    localparam int unsigned DARK_CYC     = DARK_MS * CLK_KHZ;
    localparam int unsigned LAMP_CYC     = LAMP_TEST_MS * CLK_KHZ;
    localparam int unsigned TONE_CYC     = TONE_MS * CLK_KHZ;

    // Lamp group widths
    localparam int unsigned VERT_W = 5;
    localparam int unsigned HORZ_W = 4;
    localparam int unsigned INTN_W = 3;
    localparam int unsigned RED_W  = 8;
    localparam int unsigned TRIG_W = 4;
    localparam int unsigned PLUG_W = 8;

    // Vertical mode lamp positions
    localparam int unsigned V_LEFT  = 0;
    localparam int unsigned V_SWAP  = 1;
    localparam int unsigned V_ADD   = 2;
    localparam int unsigned V_INTL  = 3;
    localparam int unsigned V_RIGHT = 4;
    // Horizontal mode lamp positions
    localparam int unsigned H_A    = 0;
    localparam int unsigned H_SWAP = 1;
    localparam int unsigned H_INTL = 2;
    localparam int unsigned H_B    = 3;
    // Intensity lamp positions
    localparam int unsigned I_STORED = 0;
    localparam int unsigned I_A      = 1;
    localparam int unsigned I_B      = 2;

    // Test order
    localparam logic [1:0] TEST_RAM  = 2'h0;
    localparam logic [1:0] TEST_ROM  = 2'h1;
    localparam logic [1:0] TEST_RTC  = 2'h2;
    localparam logic [1:0] TEST_DISP = 2'h3;
    localparam logic [1:0] TEST_LAST = TEST_DISP;

    // Preset values
    localparam logic [9:0] PRESET_POINTS = 10'h200;
    localparam logic [1:0] MSG_SELF_TEST_COMPLETE = 2'h1;

    typedef enum logic [2:0] {
        ST_DARK  = 3'b000,
        ST_LAMP  = 3'b001,
        ST_START = 3'b010,
        ST_WAIT  = 3'b011,
        ST_FAULT = 3'b100,
        ST_TONE  = 3'b101,
        ST_DONE  = 3'b110
    } pust_state_t;

    typedef struct packed {
        logic [VERT_W-1:0] vert;
        logic [HORZ_W-1:0] horiz;
        logic [INTN_W-1:0] inten;
        logic [RED_W-1:0]  red;
    } pust_lamps_t;

    typedef struct packed {
        logic       start;
        logic [1:0] sel;
    } pust_test_req_t;

    typedef struct packed {
        logic done;
        logic pass;
    } pust_test_rsp_t;

    typedef struct packed {
        logic       load;
        logic       run_program_state;
        logic       clear_prog_mem;
        logic       clear_stack;
        logic [9:0] points;
    } pust_preset_t;

    typedef struct packed {
        logic       wr;
        logic [1:0] id;
    } pust_msg_t;

endpackage : pust_pkg

/* pust_checker.sv */
// Port checker for the self-test sequencer.
// Bound into pust_sequencer; one clock, async low reset.
module pust_checker #(
    parameter int unsigned DARK_CYC = pust_pkg::DARK_CYC,
    parameter int unsigned TONE_CYC = pust_pkg::TONE_CYC
) (
    input wire logic                     core_clk_i,
    input wire logic                     arst_n_i,
    input wire logic [4:0]               vert_btn_i,
    input wire logic [3:0]               horiz_btn_i,
    input wire pust_pkg::pust_test_rsp_t test_rsp_i,
    input wire pust_pkg::pust_lamps_t    lamps_o,
    input wire pust_pkg::pust_test_req_t test_req_o,
    input wire logic                     tone_o,
    input wire pust_pkg::pust_msg_t      msg_o,
    input wire pust_pkg::pust_preset_t   preset_o,
    input wire logic                     busy_o
);
    // Horizontal fault codes, check 0 in the low nibble
    localparam logic [15:0] CODES = 16'h2c48;
    logic [31:0] up_r;
    logic [31:0] tone_r;
    logic [1:0]  sel_r;
    logic        btn;
    logic        flt;
    assign btn = |{vert_btn_i, horiz_btn_i};
    assign flt = busy_o && &lamps_o.vert && lamps_o.inten == '0;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            up_r   <= '0;
            tone_r <= '0;
            sel_r  <= '0;
        end else begin
            up_r   <= up_r + 32'(up_r < DARK_CYC + 2);
            tone_r <= tone_o ? tone_r + 32'h1 : '0;
            sel_r  <= sel_r + 2'(test_req_o.start);
        end
    end
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence press_s;
        flt ##0 (btn && !$past(btn));
    endsequence
    dark_hold_a:
        assert property (up_r + 2 <= DARK_CYC |-> lamps_o == '0) else $error("lit early");
    lamp_test_a:
        assert property (up_r == DARK_CYC + 1 |-> &lamps_o) else $error("no lamp test");
    fault_code_a:
        assert property (test_rsp_i.done && !test_rsp_i.pass |=> flt && lamps_o.red == '0
            && lamps_o.horiz == CODES[4*test_req_o.sel +: 4]) else $error("bad code");
    fault_hold_a:
        assert property (flt && !btn |=> $stable(lamps_o) && !test_req_o.start)
            else $error("fault not held");
    resume_a:
        assert property (press_s |=> &lamps_o) else $error("no resume");
    check_order_a:
        assert property (test_req_o.start |-> test_req_o.sel == sel_r ##1 !test_req_o.start)
            else $error("bad order");
    tone_len_a:
        assert property ($fell(tone_o) |-> tone_r == TONE_CYC) else $error("bad tone");
    pass_end_a:
        assert property (msg_o.wr |-> msg_o.id == pust_pkg::MSG_SELF_TEST_COMPLETE
            && preset_o.load && preset_o.points == pust_pkg::PRESET_POINTS
            && lamps_o == 20'h0c400) else $error("bad pass end");
endmodule : pust_checker

bind pust_sequencer pust_checker #(.DARK_CYC(DARK_CYC), .TONE_CYC(TONE_CYC)) u_chk (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .vert_btn_i(vert_btn_i),
    .horiz_btn_i(horiz_btn_i), .test_rsp_i(test_rsp_i), .lamps_o(lamps_o),
    .test_req_o(test_req_o), .tone_o(tone_o), .msg_o(msg_o), .preset_o(preset_o),
    .busy_o(busy_o));

/* pust_test_model.sv */
// Stand-in for the four check engines.
// Answers each start after wait_i cycles; verdict from fail_i.
module pust_test_model (
    input wire logic                     core_clk_i,
    input wire logic                     arst_n_i,
    input wire pust_pkg::pust_test_req_t req_i,
    input wire logic [3:0]               fail_i,
    input wire logic [3:0]               wait_i,
    output pust_pkg::pust_test_rsp_t     rsp_o
);
    logic       run_r;
    logic       junk_r;
    logic [3:0] cnt_r;
    logic [1:0] sel_r;
    logic       done;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            {run_r, junk_r, cnt_r, sel_r} <= '0;
        end else begin
            junk_r <= !junk_r;
            if (req_i.start) {run_r, cnt_r, sel_r} <= {1'b1, wait_i, req_i.sel};
            else if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
            else run_r <= 1'b0;
        end
    end
    assign done = run_r && cnt_r == 4'h0;
    // Verdict means nothing without done, so it toggles then
    assign rsp_o = {done, done ? !fail_i[sel_r] : junk_r};
endmodule : pust_test_model

/* tb.sv */
// Bench for the self-test sequencer: pass, beeper off, faults, back-up.
// Short counts keep the run brief; pust_test_model answers the checks.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DARK = 20;
    localparam int TONE = 5;
    localparam logic [19:0] PASS = 20'h0c400;
    localparam logic [15:0] CODES = 16'h2c48;
    logic                     core_clk_i = 1'b0;
    logic                     arst_n_i = 1'b0;
    logic                     bkp = 1'b0;
    logic                     beep = 1'b0;
    logic [4:0]               vbtn = '0;
    logic [3:0]               hbtn = '0;
    logic [3:0]               fmask = '0;
    logic [3:0]               dly = '0;
    logic [3:0]               ta;
    logic [3:0]               tbl;
    logic [7:0]               pl;
    logic [15:0]              sel = 16'h3ca5;
    logic                     pwr, tone, busy, fail;
    pust_pkg::pust_test_req_t req;
    pust_pkg::pust_test_rsp_t rsp;
    pust_pkg::pust_lamps_t    lamps;
    pust_pkg::pust_msg_t      msg;
    pust_pkg::pust_preset_t   pre;
    int failures = 0;
    int checks = 0;
    int cyc = 0;
    int n, n_tone, n_msg, n_pre, n_go;
    always #20 core_clk_i = ~core_clk_i;
    pust_sequencer #(.DARK_CYC(DARK), .LAMP_CYC(10), .TONE_CYC(TONE)) DUT (
        .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .backup_pwr_i(bkp),
        .beeper_en_i(beep), .vert_btn_i(vbtn), .horiz_btn_i(hbtn),
        .trig_a_sel_i(sel[3:0]), .trig_b_sel_i(sel[7:4]), .plugin_sel_i(sel[15:8]),
        .test_rsp_i(rsp), .power_lamp_o(pwr), .trig_a_lamp_o(ta), .trig_b_lamp_o(tbl),
        .plugin_lamp_o(pl), .lamps_o(lamps), .test_req_o(req), .tone_o(tone),
        .msg_o(msg), .preset_o(pre), .busy_o(busy), .fail_o(fail));
    pust_test_model ENG (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .req_i(req),
        .fail_i(fmask), .wait_i(dly), .rsp_o(rsp));
    always @(posedge core_clk_i) begin
        cyc++;
        if (arst_n_i) begin
            n_tone += int'(tone);
            n_msg += int'(msg.wr);
            n_pre += int'(pre.load);
            n_go += int'(req.start);
        end
        if (cyc == 5000) begin
            failures++;
            wrap_up();
        end
    end
    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wrap_up();
        if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : wrap_up
    task automatic power_up(input logic b, input logic e, input logic [3:0] m,
                            input logic [3:0] d);
        @(posedge core_clk_i);
        arst_n_i <= 1'b0;
        bkp <= b;
        beep <= e;
        fmask <= m;
        dly <= d;
        sel <= ~sel;
        repeat (12) @(posedge core_clk_i);
        {n_tone, n_msg, n_pre, n_go} = '0;
        arst_n_i <= 1'b1;
        repeat (5) @(negedge core_clk_i);
        chk("dark lamps", '0, lamps);
        chk("power lamp", 20'h1, 20'(pwr));
        chk("selected lamps", 20'(sel), 20'({pl, tbl, ta}));
        for (n = 0; n < 40 && !(&lamps); n++) @(negedge core_clk_i);
        chk("dark cycles", 20'(DARK - 4), 20'(n));
        chk("lamp test", 20'hfffff, lamps);
    endtask : power_up
    task automatic end_run(input int go, input logic [19:0] lmp, input int tn, input int ok,
                           input logic fl);
        for (n = 0; n < 400 && busy !== 1'b0; n++) @(negedge core_clk_i);
        chk("busy", '0, 20'(busy));
        chk("final lamps", lmp, lamps);
        chk("fail flag", 20'(fl), 20'(fail));
        chk("checks run", 20'(go), 20'(n_go));
        chk("tone cycles", 20'(tn), 20'(n_tone));
        chk("messages", 20'(ok), 20'(n_msg));
        chk("presets", 20'(ok), 20'(n_pre));
        chk("points", ok ? 20'h200 : 20'h0, 20'(pre.points));
    endtask : end_run
    initial begin
        power_up(1'b0, 1'b1, 4'h0, 4'h0);
        end_run(4, PASS, TONE, 1, 1'b0);
        power_up(1'b0, 1'b0, 4'h0, 4'h6);
        end_run(4, PASS, 0, 1, 1'b0);
        power_up(1'b0, 1'b1, 4'hf, 4'h3);
        for (int i = 0; i < 4; i++) begin
            for (n = 0; n < 60 && !(busy && &lamps.vert && lamps.inten == '0); n++)
                @(negedge core_clk_i);
            repeat (3) @(negedge core_clk_i);
            chk("fault vertical", 20'h1f, 20'(lamps.vert));
            chk("fault horizontal", 20'(CODES[4*i +: 4]), 20'(lamps.horiz));
            chk("checks while paused", 20'(i + 1), 20'(n_go));
            @(posedge core_clk_i);
            vbtn <= i[0] ? 5'h0 : 5'(1 << i);
            hbtn <= i[0] ? 4'(1 << i) : 4'h0;
            @(posedge core_clk_i);
            vbtn <= '0;
            hbtn <= '0;
            repeat (2) @(posedge core_clk_i);
        end
        end_run(4, 20'hfffff, 0, 0, 1'b1);
        power_up(1'b1, 1'b1, 4'h0, 4'h0);
        end_run(0, PASS, 0, 0, 1'b0);
        wrap_up();
    end
endmodule : tb
